//--- seb_map.svh
/*
  Constants of the serial memory slave: type codes, sizes and the
  programming time. Assumes it is included by bare name after the package.
*/
`ifndef SEB_MAP_SVH
`define SEB_MAP_SVH

// Slave address type codes in the upper nibble.
`define SEB_TYPE_MAIN 4'hA
`define SEB_TYPE_ID 4'hB

// Array organisation.
`define SEB_MEM_BYTES 1024
`define SEB_ADDR_W 10
`define SEB_PAGE_BYTES 16
`define SEB_BLOCK_BYTES 256

// Address and data byte field positions.
`define SEB_DEV_RW_BIT 0
`define SEB_DEV_STRAP_BIT 3
`define SEB_WADDR_LOCK_BIT 7
`define SEB_LOCK_DATA_BIT 1

// Bit counts within one byte slot.
`define SEB_BITS_BYTE 4'h8
`define SEB_BITS_SLOT 4'h9

// Write buffer depth.
`define SEB_FIFO_DEPTH 16

// Self-timed programming time, in ms, and the clock rate in kHz.
`define SEB_TWR_MS 5
`define SEB_CLK_KHZ 100000
`define SEB_TWR_CYC (`SEB_TWR_MS * `SEB_CLK_KHZ)

`endif

//--- seb_pkg.sv
/*
  Types shared by the serial memory slave modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package seb_pkg;

  // Protocol phase of the slave.
  typedef enum logic [2:0] {
    SEB_IDLE = 3'b000,
    SEB_DEV = 3'b001,
    SEB_WADDR = 3'b010,
    SEB_WDATA = 3'b011,
    SEB_READ = 3'b100
  } seb_state_t;

  // One buffered write: target page, location and byte.
  typedef struct packed {
    logic id;
    logic [9:0] addr;
    logic [7:0] data;
  } seb_entry_t;

endpackage

//--- seb_stream_if.sv
/*
  Valid and ready stream carrying buffered writes between the modules.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface seb_stream_if;
  import seb_pkg::*;

  logic valid;
  logic ready;
  seb_entry_t data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- seb_fifo.sv
/*
  Small synchronous FIFO with valid and ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module seb_fifo #(
  parameter int DEPTH = 16,
  parameter int WIDTH = $bits(seb_pkg::seb_entry_t),
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rstn,
  seb_stream_if.snk wr,
  seb_stream_if.src rd
);
  import seb_pkg::*;

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  wire full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  wire empty = (wptr == rptr);
  wire push = wr.valid && !full;
  wire pop = rd.ready && !empty;

  // Flags come straight from the pointers, so they never lie.
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = store[rptr[AW-1:0]];

  // Pointer update.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) wptr <= wptr + 1'b1;
      if (pop) rptr <= rptr + 1'b1;
    end
  end

  // Storage needs no reset; it is only read while not empty.
  always_ff @(posedge clk) begin
    if (push) store[wptr[AW-1:0]] <= wr.data;
  end
endmodule

//--- seb_prog_timer.sv
/*
  Self-timed programming interval: a pulse on go holds busy high for
  CYCLES clocks. Assumes go is a single-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
module seb_prog_timer #(
  parameter int CYCLES = 500000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic go,
  output logic busy
);
  logic [31:0] remain;

  // Count down; a go while busy is ignored since the slave refuses writes.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      remain <= 32'h0;
    end else if (go && remain == 32'h0) begin
      remain <= CYCLES[31:0];
    end else if (remain != 32'h0) begin
      remain <= remain - 32'h1;
    end
  end

  assign busy = (remain != 32'h0);
endmodule

//--- seb_eeprom_slave.sv
/*
  Two-wire slave front end of a 1024 x 8 nonvolatile memory with an
  optional 16-byte identification page, write buffer and self-timed
  programming. Assumes scl, sda and the strap and protect pins are
  asynchronous pins, sda has an external pull-up, and the unconnected
  strap and protect pins are pulled low on the board.
*/
// Notes on behaviour
// - Start: SDA falls, SCL high; needed first.
// - Stop: SDA rises, SCL high; ends operation.
// - Data changes only while SCL low.
// - Receiver acknowledges each byte, ninth clock.
// - Main array needs type nibble 1010.
// - Bits 2 and 1 pick 256-byte block.
// - Bit 3 must equal strap pin.
// - Floating strap counts as zero; here the pin is sampled as is and the board must pull it low.
// - Address bit 0: 1 read, 0 write.
// - Acknowledge matching address, then serve.
// - Optional identification page, own type code.
// - Write protect high rejects all writes.
// - Start resets interface after aborted transfer.
// - Standby after power-up, reads, programming.
// - Ignore commands while power-on reset held.
// - 1024 bytes in 16-byte pages.
// - Programming self-timed, at most 5 ms.
// - SDA only pulled low or released.
// - Identification page lockable permanently; here the lock flag clears on rstn.
// - Identification page type nibble 1011.
// - No responses while programming runs.
`timescale 1ns/1ps
`include "seb_map.svh"
module seb_eeprom_slave #(
  parameter int TWR_CYCLES = `SEB_TWR_CYC,
  parameter bit ID_PAGE_EN = 1'b1,
  parameter int FIFO_DEPTH = `SEB_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic chip_strap_input,
  input wire logic write_protect,
  output logic busy,
  output logic standby,
  output seb_pkg::seb_state_t phase
);
  import seb_pkg::*;

  // Pin synchronisers; the first stage feeds only the second.
  logic scl_m, scl_s, scl_p;
  logic sda_m, sda_s, sda_p;
  logic strap_m, strap_s;
  logic wp_m, wp_s;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      {scl_m, scl_s, scl_p} <= 3'h7;
      {sda_m, sda_s, sda_p} <= 3'h7;
      {strap_m, strap_s, wp_m, wp_s} <= 4'h0;
    end else begin
      {scl_m, scl_s, scl_p} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {sda_in, sda_m, sda_s};
      {strap_m, strap_s, wp_m, wp_s} <= {chip_strap_input, strap_m, write_protect, wp_m};
    end
  end

  // Bus events seen at clk rate, independent of SCL edges.
  wire start_ev = scl_s && scl_p && sda_p && !sda_s;
  wire stop_ev = scl_s && scl_p && !sda_p && sda_s;
  wire scl_rise = scl_s && !scl_p;
  wire scl_fall = !scl_s && scl_p;

  // Slave state.
  seb_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] rd_shift;
  logic [9:0] addr;
  logic [1:0] blk;
  logic is_id;
  logic lock_cmd;
  logic id_locked;
  logic ack_drive;
  logic data_drive;
  logic master_ack;
  logic wr_pend;
  logic prog_go;
  logic prog_busy;

  // Array and identification page storage.
  logic [7:0] mem [`SEB_MEM_BYTES];
  logic [7:0] id_mem [`SEB_PAGE_BYTES];

  // Address byte decode on the byte just shifted in.
  wire [3:0] dev_type = shreg[7:4];
  wire strap_ok = (shreg[`SEB_DEV_STRAP_BIT] == strap_s);
  wire main_hit = (dev_type == `SEB_TYPE_MAIN) && strap_ok;
  wire id_hit = ID_PAGE_EN && (dev_type == `SEB_TYPE_ID) && strap_ok;
  wire dev_hit = (main_hit || id_hit) && !prog_busy;
  wire rw_read = shreg[`SEB_DEV_RW_BIT];
  wire byte_done = scl_fall && (bitcnt == `SEB_BITS_BYTE);
  wire slot_done = scl_fall && (bitcnt == `SEB_BITS_SLOT);

  // Write acceptance: protect pin, lock and buffer space all gate it.
  seb_stream_if wbuf ();
  seb_stream_if dbuf ();
  wire id_refused = is_id && id_locked;
  wire wr_ok = !wp_s && !id_refused && wbuf.ready;
  wire take_data = byte_done && (state == SEB_WDATA) && wr_ok;

  assign wbuf.valid = take_data;
  assign wbuf.data = '{id: is_id, addr: addr, data: shreg};

  // Location arithmetic: page-wrapped for writes and identification page reads, linear for main array reads.
  function automatic logic [9:0] page_next(input logic [9:0] a);
    page_next = {a[9:4], a[3:0] + 4'h1};
  endfunction

  function automatic logic [9:0] lin_next(input logic [9:0] a, input logic id);
    lin_next = id ? page_next(a) : a + 10'h001;
  endfunction

  // Byte served to the master for a read.
  wire [7:0] rd_byte = is_id ? id_mem[addr[3:0]] : mem[addr];

  // Bit counter: counts SCL rises within one nine-bit slot.
  always_ff @(posedge clk) begin
    if (!rstn || start_ev || stop_ev) begin
      bitcnt <= 4'h0;
    end else if (slot_done) begin
      bitcnt <= 4'h0;
    end else if (scl_rise && state != SEB_IDLE && bitcnt < `SEB_BITS_SLOT) begin
      bitcnt <= bitcnt + 4'h1;
    end
  end

  // Receive shift register, sampled while SCL is high.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shreg <= 8'h00;
    end else if (scl_rise && bitcnt < `SEB_BITS_BYTE) begin
      shreg <= {shreg[6:0], sda_s};
    end
  end

  // Master acknowledge after each byte read out, sampled at the ninth rise.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      master_ack <= 1'b0;
    end else if (scl_rise && bitcnt == `SEB_BITS_BYTE) begin
      master_ack <= !sda_s;
    end
  end

  // Protocol sequencer. Start wins over everything, so a stuck transfer
  // is always recoverable by clocking the bus free and sending a start.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= SEB_IDLE;
      ack_drive <= 1'b0;
      blk <= 2'h0;
      is_id <= 1'b0;
      lock_cmd <= 1'b0;
    end else if (start_ev) begin
      state <= SEB_DEV;
      ack_drive <= 1'b0;
    end else if (stop_ev) begin
      state <= SEB_IDLE;
      ack_drive <= 1'b0;
    end else if (byte_done) begin
      case (state)
        SEB_DEV: begin
          if (dev_hit) begin
            ack_drive <= 1'b1;
            blk <= shreg[2:1];
            is_id <= id_hit;
            state <= rw_read ? SEB_READ : SEB_WADDR;
          end else begin
            state <= SEB_IDLE;
          end
        end
        SEB_WADDR: begin
          ack_drive <= 1'b1;
          lock_cmd <= is_id && shreg[`SEB_WADDR_LOCK_BIT];
          state <= SEB_WDATA;
        end
        SEB_WDATA: begin
          ack_drive <= wr_ok;
        end
        default: begin
          ack_drive <= 1'b0;
        end
      endcase
    end else if (slot_done) begin
      ack_drive <= 1'b0;
      if (state == SEB_READ && !master_ack && !data_drive) state <= SEB_IDLE;
    end
  end

  // Location pointer: set by the word address, advanced per byte moved.
  // A page pointer keeps the lock flag in bit 7, so the buffered entry
  // still carries it when the byte is committed.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      addr <= 10'h000;
    end else if (byte_done && state == SEB_WADDR) begin
      addr <= is_id ? {2'h0, shreg[`SEB_WADDR_LOCK_BIT], 3'h0, shreg[3:0]} : {blk, shreg};
    end else if (take_data && !lock_cmd) begin
      addr <= page_next(addr);
    end else if (slot_done && state == SEB_READ && (data_drive || master_ack)) begin
      addr <= lin_next(addr, is_id);
    end
  end

  // Read data path. The first byte goes out after our own acknowledge,
  // later ones only after the master acknowledges the previous byte.
  always_ff @(posedge clk) begin
    if (!rstn || start_ev || stop_ev) begin
      data_drive <= 1'b0;
      rd_shift <= 8'h00;
    end else if (slot_done && state == SEB_READ && (ack_drive || master_ack)) begin
      rd_shift <= rd_byte;
      data_drive <= 1'b1;
    end else if (scl_fall && state == SEB_READ && data_drive) begin
      if (bitcnt == `SEB_BITS_BYTE) begin
        data_drive <= 1'b0;
      end else if (bitcnt != 4'h0) begin
        rd_shift <= {rd_shift[6:0], 1'b0};
      end
    end
  end

  // A stop after accepted data launches the programming cycle.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      prog_go <= 1'b0;
    end else begin
      prog_go <= stop_ev && (wr_pend || take_data);
      if (take_data) begin
        wr_pend <= 1'b1;
      end else if (stop_ev) begin
        wr_pend <= 1'b0;
      end
    end
  end

  // Write buffer between the bus and the array.
  seb_fifo #(
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .wr(wbuf.snk),
    .rd(dbuf.src)
  );

  // The array drains the buffer only while programming, which is what
  // makes the buffer fill during a page transfer.
  seb_prog_timer #(
    .CYCLES(TWR_CYCLES)
  ) u_timer (
    .clk(clk),
    .rstn(rstn),
    .go(prog_go),
    .busy(prog_busy)
  );

  assign dbuf.ready = prog_busy;
  wire commit = dbuf.valid && dbuf.ready;
  wire commit_lock = dbuf.data.id && dbuf.data.addr[`SEB_WADDR_LOCK_BIT];

  // Commit buffered bytes; a lock byte with its flag bit set seals the page.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      id_locked <= 1'b0;
    end else if (commit && commit_lock && dbuf.data.data[`SEB_LOCK_DATA_BIT]) begin
      id_locked <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (commit && !dbuf.data.id) mem[dbuf.data.addr] <= dbuf.data.data;
    if (commit && dbuf.data.id && !commit_lock) id_mem[dbuf.data.addr[3:0]] <= dbuf.data.data;
  end

  // Open-drain pin: only ever pulls low, the pull-up makes the one.
  wire pull_low = ack_drive || (data_drive && !rd_shift[7]);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      busy <= 1'b0;
      standby <= 1'b1;
      phase <= SEB_IDLE;
    end else begin
      sda_out <= 1'b0;
      sda_oe <= pull_low;
      busy <= prog_busy;
      standby <= (state == SEB_IDLE) && !prog_busy && !prog_go;
      phase <= state;
    end
  end
endmodule

//--- seb_eeprom_slave_assertions.sv
/*
  Checker of the slave's pin behaviour.
  Assumes it is bound onto seb_eeprom_slave.
*/
`timescale 1ns/1ps
module seb_eeprom_slave_assertions
  import seb_pkg::*;
#(
  parameter int TWR_CYCLES = 200
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic chip_strap_input,
  input wire logic write_protect,
  input wire logic busy,
  input wire logic standby,
  input wire seb_pkg::seb_state_t phase
);
  logic scl_d;
  logic sda_d;
  int unsigned busy_cnt;

  // Raw pin history, so start and stop are judged on the wires.
  always_ff @(posedge clk) begin
    scl_d <= scl_in;
    sda_d <= sda_in;
  end

  // Counts programming cycles; idle clears it.
  always_ff @(posedge clk) begin
    if (!rstn || !busy)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
  end

  sequence start_seq;
    scl_d && scl_in && sda_d && !sda_in;
  endsequence
  sequence stop_seq;
    scl_d && scl_in && !sda_d && sda_in;
  endsequence

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_OPEN_DRAIN: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high");
  AST_RESET_STATE: assert property ($rose(rstn) |->
    phase == SEB_IDLE && standby && !sda_oe && !busy)
    else $error("state not reset");
  AST_START_ADDR: assert property (start_seq and !busy |-> ##[1:6] phase == SEB_DEV)
    else $error("start not taken");
  AST_STOP_IDLE: assert property (stop_seq |-> ##[1:6] phase == SEB_IDLE)
    else $error("stop not taken");
  AST_BUSY_QUIET: assert property (busy |-> !sda_oe && !standby)
    else $error("answer while programming");
  AST_PROG_TIME: assert property ($fell(busy) |-> busy_cnt == TWR_CYCLES)
    else $error("programming time wrong");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda changed with scl high");
  AST_IDLE_RELEASE: assert property (phase == SEB_IDLE |-> !sda_oe)
    else $error("sda held while idle");
endmodule

//--- seb_bus_master.sv
/*
  Behavioural two-wire bus master: drives SCL and pulls SDA low.
  Assumes the SDA wire and its pull-up are resolved outside.
*/
`timescale 1ns/1ps
module seb_bus_master (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // Quarter of the 125 ns period; SCL stands high between frames.
  localparam realtime Q = 31.25;

  // Bus starts idle with both lines released.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Start or repeated start: SDA falls while SCL is high.
  task automatic start();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask

  // Stop: the frame closes with SDA rising while SCL is high.
  task automatic stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask

  // Data moves only while SCL is low and is sampled mid-high.
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask

  // Byte MSB first; nine high releases SDA for the answer.
  task automatic xfer(input logic [7:0] tx, input logic nine,
                      output logic [7:0] rx, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(nine, a);
    ack = !a;
  endtask
endmodule

//--- seb_eeprom_slave_test.sv
/*
  Self-checking bench of the serial memory slave.
  Assumes the bus master model and the checker are compiled first.
*/
`timescale 1ns/1ps
module seb_eeprom_slave_test;
  import seb_pkg::*;
  localparam int TWR = 200;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic strap = 1'b0;
  logic wp = 1'b0;
  logic scl, m_low, sda_out, sda_oe, busy, standby, ack;
  wire sda;
  seb_state_t phase;
  int error_cnt = 0;
  int total_checks = 0;
  logic [7:0] ref_mem [0:1023];
  logic [7:0] rx, d;
  int blk, word, base;

  // Pull-up wire: low while either party pulls.
  assign sda = !(m_low || (sda_oe && !sda_out));
  seb_bus_master m (.scl(scl), .sda_low(m_low), .sda(sda));
  seb_eeprom_slave #(.TWR_CYCLES(TWR)) DUT (.clk(clk), .rstn(rstn), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .chip_strap_input(strap),
    .write_protect(wp), .busy(busy), .standby(standby), .phase(phase));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One byte out, with the expected answer on the ninth clock.
  task automatic put(input logic [7:0] b, input logic exp_ack);
    m.xfer(b, 1'b1, rx, ack);
    check(ack, exp_ack);
  endtask

  // Bounded wait; a hang is counted and ends the run.
  task automatic wait_busy(input logic lvl);
    int n;
    for (n = 0; n < 1000 && busy !== lvl; n++) @(posedge clk);
    if (n == 1000) begin
      error_cnt++;
      final_report();
    end
  endtask

  // Loads the location pointer, as writes and dummy writes do.
  task automatic set_ptr(input logic [3:0] ty, input int b, input int w);
    m.start();
    put({ty, strap, b[1:0], 1'b0}, 1'b1);
    put(w[7:0], 1'b1);
  endtask

  // Dummy write, then one byte read back and closed by a nack.
  task automatic get(input logic [3:0] ty, input int b, input int w);
    set_ptr(ty, b, w);
    m.start();
    put({ty, strap, b[1:0], 1'b1}, 1'b1);
    m.xfer(8'hFF, 1'b1, rx, ack);
    m.stop();
  endtask

  initial begin
    void'($urandom(8467));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 check({busy, standby, sda_oe, phase}, {3'b010, SEB_IDLE});
    // Every type code under both strap levels; only a full match answers.
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      strap <= s[0];
      for (int t = 0; t < 16; t++) begin
        d = {t[3:0], 4'($urandom)};
        d[0] = 1'b0;
        m.start();
        put(d, (t == 10 || t == 11) && d[3] == s[0]);
        m.stop();
      end
    end
    // Page write of 17 bytes: the pointer wraps and the 17th is refused.
    blk = $urandom_range(3, 0);
    word = $urandom_range(255, 0);
    base = blk * 256 + word / 16 * 16;
    set_ptr(4'hA, blk, word);
    for (int i = 0; i < 17; i++) begin
      d = 8'($urandom);
      if (i < 16) ref_mem[base + (word + i) % 16] = d;
      put(d, i < 16);
    end
    m.stop();
    wait_busy(1'b1);
    check(standby, 1'b0);
    // Polling while programming gets no answer.
    m.start();
    put({4'hA, strap, 3'b000}, 1'b0);
    m.stop();
    wait_busy(1'b0);
    repeat (2) @(posedge clk);
    check(standby, 1'b1);
    // Random read of the page, master acks all but the last byte.
    set_ptr(4'hA, blk, base % 256);
    m.start();
    put({4'hA, strap, blk[1:0], 1'b1}, 1'b1);
    for (int i = 0; i < 16; i++) begin
      m.xfer(8'hFF, i == 15, rx, ack);
      check(rx, ref_mem[base + i]);
    end
    m.stop();
    // Protected writes are refused and start no programming.
    @(posedge clk);
    wp <= 1'b1;
    set_ptr(4'hA, blk, base % 256);
    put(~ref_mem[base], 1'b0);
    m.stop();
    repeat (10) @(posedge clk);
    check(busy, 1'b0);
    get(4'hA, blk, base % 256);
    check(rx, ref_mem[base]);
    @(posedge clk);
    wp <= 1'b0;
    // Identification page: write, read back, lock, then writes are refused.
    d = 8'($urandom);
    set_ptr(4'hB, 2'h0, 8'h03);
    put(d, 1'b1);
    m.stop();
    wait_busy(1'b1);
    wait_busy(1'b0);
    get(4'hB, 2'h0, 8'h03);
    check(rx, d);
    set_ptr(4'hB, 2'h0, 8'h80);
    put(8'h02, 1'b1);
    m.stop();
    wait_busy(1'b1);
    wait_busy(1'b0);
    set_ptr(4'hB, 2'h0, 8'h03);
    put(~d, 1'b0);
    m.stop();
    get(4'hB, 2'h0, 8'h03);
    check(rx, d);
    // Abort mid-byte, clock SDA high, then a fresh address must answer.
    m.start();
    for (int i = 0; i < 4; i++) m.bit_io(1'b1, ack);
    m.start();
    put({4'hA, strap, 3'b000}, 1'b1);
    // Reset in mid-transfer returns the state to standby.
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check({busy, standby, sda_oe, phase}, {3'b010, SEB_IDLE});
    rstn <= 1'b1;
    m.stop();
    final_report();
  end
endmodule

bind seb_eeprom_slave seb_eeprom_slave_assertions #(.TWR_CYCLES(TWR_CYCLES)) u_chk (
  .clk(clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .chip_strap_input(chip_strap_input), .write_protect(write_protect),
  .busy(busy), .standby(standby), .phase(phase));
